// file: rtl/dpac_params.svh
// timing, offset, field and reset-value constants of the debug port access control
`ifndef DPAC_PARAMS_SVH
`define DPAC_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (plain register port, word index)
// ----------------------------------------------------------------------
`define DPAC_OFS_CTRL      4'h0
`define DPAC_OFS_PORTSEL   4'h1
`define DPAC_OFS_STATUS    4'h2
`define DPAC_OFS_MBOX_IN   4'h3
`define DPAC_OFS_MBOX_OUT  4'h4

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define DPAC_CTRL_DBGEN    0
`define DPAC_CTRL_TOJTAG   1
`define DPAC_CTRL_CLRSPEED 2

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define DPAC_ST_LOCK       0
`define DPAC_ST_SWD        1
`define DPAC_ST_TAPRST     2
`define DPAC_ST_SPEED      3
`define DPAC_ST_DBGEN      4
`define DPAC_ST_PINS_LO    8
`define DPAC_ST_PINS_HI    10
`define DPAC_ST_TAP_LO     12
`define DPAC_ST_TAP_HI     15

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DPAC_RST_PORTSEL   3'h0
`define DPAC_RST_CTRL      3'h0

// ----------------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------------
`define DPAC_IR_EXTEST     4'h0
`define DPAC_IR_IDCODE     4'h1
`define DPAC_IR_SAMPLE     4'h2
`define DPAC_IR_DBGACC     4'h8
`define DPAC_IR_RSTREQ     4'h9
`define DPAC_IR_BYPASS     4'hF

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DPAC_CLK_PS        4000
`define DPAC_KEY_WIN_NS    8000
`define DPAC_KEY_WIN_CYC   ((`DPAC_KEY_WIN_NS * 1000) / `DPAC_CLK_PS)
`define DPAC_TCK_MAX_MHZ   8
`define DPAC_TCK_MIN_CYC   ((1000000 / `DPAC_TCK_MAX_MHZ + `DPAC_CLK_PS - 1) / `DPAC_CLK_PS)
`define DPAC_CPU_RATIO_16  3
`define DPAC_CPU_RATIO_32  5

`endif

// file: rtl/dpac_pkg.sv
// types shared by the debug port access control files
package dpac_pkg;

   // tap controller states
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
      TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
   } dpac_tap_t;

   // debug port select setting
   typedef enum logic [2:0] {
      PS_JTAG4, PS_JTAG5, PS_SWD, PS_SWD_VIEW, PS_VIEW, PS_OFF
   } dpac_psel_t;

endpackage : dpac_pkg

// file: rtl/dpac_sync.sv
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none

module dpac_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] dout
);

   // ------------------------------------------------------------------
   // per-bit flop pair; first stage is read only by the second
   // ------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               meta    <= 1'b0;
               dout[i] <= 1'b0;
            end else begin
               meta    <= din[i];
               dout[i] <= meta;
            end
         end
      end
   endgenerate

endmodule : dpac_sync

`default_nettype wire

// file: rtl/dpac_port_ctrl.sv
// debug port access control: tap controller, port select, lockout, wire acquisition
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

`include "dpac_params.svh"

module dpac_port_ctrl
   import dpac_pkg::*;
#(
   parameter int          BS_W     = 8,
   parameter logic [31:0] ID_CODE  = 32'h1234_5001,  // arbitrary value
   parameter logic [15:0] SWD_KEY  = 16'hA55A,       // arbitrary value
   parameter int          KEY_WIN  = `DPAC_KEY_WIN_CYC
) (
   input  wire logic            clock,
   input  wire logic            rst,
   // register port
   input  wire logic [3:0]      regAddr,
   input  wire logic [31:0]     regWrData,
   input  wire logic            regWrStb,
   input  wire logic            regRdStb,
   output var  logic [31:0]     regRdData,
   // link pins
   input  wire logic            tckPin,
   input  wire logic            tmsIn,
   output var  logic            tmsOut,
   output var  logic            tmsOe,
   input  wire logic            tdiPin,
   output var  logic            tdoOut,
   output var  logic            tdoOe,
   input  wire logic            tapResetLowPin,
   // boundary cells and system
   input  wire logic [BS_W-1:0] bsPinsIn,
   output var  logic [BS_W-1:0] bsPinsOut,
   output var  logic            bsDrive,
   input  wire logic            lockLatch,
   output var  logic            sysResetReq,
   output var  logic [4:0]      pinRelease
);

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic [3:0] pinSync;
   dpac_sync #(.W(4)) uSync (
      .clock (clock),
      .rst   (rst),
      .din   ({tapResetLowPin, tdiPin, tmsIn, tckPin}),
      .dout  (pinSync)
   );
   logic tckS, tmsS, tdiS, trstLowS, tckPrev_r, tckRise, tckFall;
   assign tckS     = pinSync[0];
   assign tmsS     = pinSync[1];
   assign tdiS     = pinSync[2];
   assign trstLowS = pinSync[3];
   assign tckRise  = tckS & ~tckPrev_r;
   assign tckFall  = ~tckS & tckPrev_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) tckPrev_r <= 1'b0;
      else     tckPrev_r <= tckS;
   end

   // ------------------------------------------------------------------
   // lockout latch caught once after reset release
   // ------------------------------------------------------------------
   logic locked_r, lockTaken_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         locked_r    <= 1'b0;
         lockTaken_r <= 1'b0;
      end else if (!lockTaken_r) begin
         locked_r    <= lockLatch;
         lockTaken_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // firmware settings
   // ------------------------------------------------------------------
   dpac_psel_t portSel_r;
   logic       dbgEn_r, toJtag_r, speedErr_r, swdActive_r;
   logic [31:0] mboxIn_r, mboxOut_r;
   logic       wrCtrl, wrPsel;
   assign wrCtrl = regWrStb && regAddr == `DPAC_OFS_CTRL;
   assign wrPsel = regWrStb && regAddr == `DPAC_OFS_PORTSEL;

   // debug enable is set-only: once on, only a fresh reset after reprogramming clears it
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dbgEn_r  <= 1'b0;
         toJtag_r <= 1'b0;
      end else if (wrCtrl) begin
         if (regWrData[`DPAC_CTRL_DBGEN]) dbgEn_r <= 1'b1;
         toJtag_r <= regWrData[`DPAC_CTRL_TOJTAG];
      end
   end

   // port select resets to four-wire tap
   always_ff @(posedge clock or posedge rst) begin
      if (rst) portSel_r <= dpac_psel_t'(`DPAC_RST_PORTSEL);
      else if (wrPsel && regWrData[2:0] <= 3'(PS_OFF))
         portSel_r <= dpac_psel_t'(regWrData[2:0]);
   end

   // ------------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------------
   logic psJtag, psOff, tapOn, viewOn, trstUsed;
   assign psJtag   = portSel_r == PS_JTAG4 || portSel_r == PS_JTAG5;
   assign psOff    = portSel_r == PS_OFF;
   assign tapOn    = !locked_r && (psJtag || (swdActive_r && toJtag_r));
   assign viewOn   = !locked_r && (portSel_r == PS_VIEW || portSel_r == PS_SWD_VIEW);
   assign trstUsed = portSel_r == PS_JTAG5;

   // pins claimed: tck, tms, tdi, tdo, trst
   always_ff @(posedge clock or posedge rst) begin
      if (rst) pinRelease <= 5'h00;
      else if (locked_r || psOff) pinRelease <= 5'h1F;
      else if (portSel_r == PS_JTAG4) pinRelease <= 5'h10;  // four pins
      else if (portSel_r == PS_JTAG5) pinRelease <= 5'h00;  // five pins
      else if (portSel_r == PS_SWD) pinRelease <= 5'h1C;    // two pins
      else if (portSel_r == PS_VIEW) pinRelease <= 5'h17;   // one pin
      else pinRelease <= 5'h14;                             // three pins
   end

   // ------------------------------------------------------------------
   // test clock speed check: period between rises in clock cycles
   // ------------------------------------------------------------------
   localparam int MINCYC = (`DPAC_TCK_MIN_CYC > `DPAC_CPU_RATIO_32) ?
                           `DPAC_TCK_MIN_CYC : `DPAC_CPU_RATIO_32;
   logic [7:0] tckCnt_r;
   logic       tckSeen_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tckCnt_r   <= 8'h00;
         tckSeen_r  <= 1'b0;
         speedErr_r <= 1'b0;
      end else begin
         if (tckRise) begin
            tckCnt_r  <= 8'h01;
            tckSeen_r <= 1'b1;
         end else if (tckCnt_r != 8'hFF) begin
            tckCnt_r <= tckCnt_r + 8'h01;
         end
         // set wins over the clear
         if (tckRise && tckSeen_r && tckCnt_r < 8'(MINCYC))
            speedErr_r <= 1'b1;
         else if (wrCtrl && regWrData[`DPAC_CTRL_CLRSPEED])
            speedErr_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // wire port acquisition inside the key window
   // ------------------------------------------------------------------
   logic [15:0] keyWin_r;
   logic [15:0] keyShift_r;
   logic [1:0]  ackCnt_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         keyWin_r    <= 16'h0000;
         keyShift_r  <= 16'h0000;
         swdActive_r <= 1'b0;
      end else begin
         if (keyWin_r != 16'(KEY_WIN)) keyWin_r <= keyWin_r + 16'h0001;
         if (tckRise) keyShift_r <= {keyShift_r[14:0], tmsS};
         if (!locked_r && keyWin_r != 16'(KEY_WIN) && tckRise
             && {keyShift_r[14:0], tmsS} == SWD_KEY)
            swdActive_r <= 1'b1;
      end
   end

   // acknowledge driven on mode-select for three falling edges after acquisition
   logic swdRose_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         swdRose_r <= 1'b0;
         ackCnt_r  <= 2'h0;
         tmsOut    <= 1'b0;
         tmsOe     <= 1'b0;
      end else begin
         swdRose_r <= swdActive_r;
         if (swdActive_r && !swdRose_r) ackCnt_r <= 2'h3;
         else if (tckFall && ackCnt_r != 2'h0) ackCnt_r <= ackCnt_r - 2'h1;
         // two-way only while not in tap mode
         tmsOe  <= swdActive_r && !toJtag_r && !psJtag && ackCnt_r != 2'h0;
         tmsOut <= ackCnt_r == 2'h3;
      end
   end

   // ------------------------------------------------------------------
   // tap state machine
   // ------------------------------------------------------------------
   dpac_tap_t tap_r, tap_nxt;
   always_comb begin
      unique case (tap_r)
         TAP_RESET:  tap_nxt = tmsS ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   tap_nxt = tmsS ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_nxt = tmsS ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_nxt = tmsS ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  tap_nxt = tmsS ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_nxt = tmsS ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: tap_nxt = tmsS ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: tap_nxt = tmsS ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tap_nxt = tmsS ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tap_nxt = tmsS ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: tap_nxt = tmsS ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  tap_nxt = tmsS ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_nxt = tmsS ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: tap_nxt = tmsS ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: tap_nxt = tmsS ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tap_nxt = tmsS ? TAP_SEL_DR : TAP_IDLE;
      endcase
   end

   // low-true tap reset only counts in five-wire mode; otherwise mode-select does it
   always_ff @(posedge clock or posedge rst) begin
      if (rst) tap_r <= TAP_RESET;
      else if (!tapOn || (trstUsed && !trstLowS)) tap_r <= TAP_RESET;
      else if (tckRise) tap_r <= tap_nxt;
   end

   // ------------------------------------------------------------------
   // instruction and data registers
   // ------------------------------------------------------------------
   logic [3:0]      ir_r, irSh_r;
   logic [31:0]     dr_r;
   logic [BS_W-1:0] bs_r;
   logic            byp_r;
   logic            dbgOk;
   assign dbgOk = dbgEn_r && !locked_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ir_r   <= `DPAC_IR_IDCODE;
         irSh_r <= 4'h0;
      end else if (tap_r == TAP_RESET) begin
         ir_r <= `DPAC_IR_IDCODE;
      end else if (tckRise) begin
         if (tap_r == TAP_CAP_IR) irSh_r <= 4'h1;
         else if (tap_r == TAP_SH_IR) irSh_r <= {tdiS, irSh_r[3:1]};
         else if (tap_r == TAP_UPD_IR) ir_r <= irSh_r;
      end
   end

   // shared data shifter; boundary cells and bypass kept apart
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dr_r  <= 32'h0000_0000;
         bs_r  <= '0;
         byp_r <= 1'b0;
      end else if (tckRise && tap_r == TAP_CAP_DR) begin
         byp_r <= 1'b0;
         bs_r  <= bsPinsIn;
         if (ir_r == `DPAC_IR_IDCODE) dr_r <= ID_CODE;
         else if (ir_r == `DPAC_IR_DBGACC && dbgOk) dr_r <= mboxOut_r;
         else dr_r <= 32'h0000_0000;
      end else if (tckRise && tap_r == TAP_SH_DR) begin
         byp_r <= tdiS;
         bs_r  <= {tdiS, bs_r[BS_W-1:1]};
         dr_r  <= {tdiS, dr_r[31:1]};
      end
   end

   // update actions: boundary drive, mailbox, reset request
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bsPinsOut   <= '0;
         bsDrive     <= 1'b0;
         mboxIn_r    <= 32'h0000_0000;
         sysResetReq <= 1'b0;
      end else begin
         sysResetReq <= 1'b0;
         bsDrive     <= tapOn && ir_r == `DPAC_IR_EXTEST;
         if (tckRise && tap_r == TAP_UPD_DR) begin
            if (ir_r == `DPAC_IR_EXTEST) bsPinsOut <= bs_r;
            if (ir_r == `DPAC_IR_DBGACC && dbgOk) mboxIn_r <= dr_r;
            if (ir_r == `DPAC_IR_RSTREQ && dr_r[31] && !psOff) sysResetReq <= 1'b1;
         end
      end
   end

   // tdo updates on every falling test clock; it is driven only while shifting
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tdoOut <= 1'b0;
         tdoOe  <= 1'b0;
      end else if (tckFall) begin
         tdoOe <= tapOn && (tap_r == TAP_SH_DR || tap_r == TAP_SH_IR);
         if (tap_r == TAP_SH_IR) tdoOut <= irSh_r[0];
         else if (ir_r == `DPAC_IR_BYPASS) tdoOut <= byp_r;
         else if (ir_r == `DPAC_IR_EXTEST || ir_r == `DPAC_IR_SAMPLE) tdoOut <= bs_r[0];
         else tdoOut <= dr_r[0];
      end else if (!tapOn) begin
         tdoOe <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // firmware mailbox and read path
   // ------------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) mboxOut_r <= 32'h0000_0000;
      else if (regWrStb && regAddr == `DPAC_OFS_MBOX_OUT) mboxOut_r <= regWrData;
   end

   logic [2:0] pinCount;
   assign pinCount = (locked_r || psOff) ? 3'd0 : portSel_r == PS_JTAG4 ? 3'd4 :
                     portSel_r == PS_JTAG5 ? 3'd5 : portSel_r == PS_SWD ? 3'd2 :
                     portSel_r == PS_VIEW ? 3'd1 : 3'd3;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) regRdData <= 32'h0000_0000;
      else if (regRdStb) begin
         regRdData <= 32'h0000_0000;
         unique case (regAddr)
            `DPAC_OFS_CTRL:    regRdData[1:0] <= {toJtag_r, dbgEn_r};
            `DPAC_OFS_PORTSEL: regRdData[2:0] <= portSel_r;
            `DPAC_OFS_STATUS: begin
               regRdData[`DPAC_ST_LOCK]   <= locked_r;
               regRdData[`DPAC_ST_SWD]    <= swdActive_r;
               regRdData[`DPAC_ST_TAPRST] <= tap_r == TAP_RESET;
               regRdData[`DPAC_ST_SPEED]  <= speedErr_r;
               regRdData[`DPAC_ST_DBGEN]  <= dbgEn_r;
               regRdData[`DPAC_ST_PINS_HI:`DPAC_ST_PINS_LO] <= pinCount;
               regRdData[`DPAC_ST_TAP_HI:`DPAC_ST_TAP_LO]   <= tap_r;
            end
            `DPAC_OFS_MBOX_IN:  regRdData <= mboxIn_r;
            `DPAC_OFS_MBOX_OUT: regRdData <= mboxOut_r;
            default:            regRdData <= 32'h0000_0000;  // unmapped reads zero
         endcase
      end else regRdData <= 32'h0000_0000;
   end

   logic unusedView;
   assign unusedView = viewOn;

endmodule : dpac_port_ctrl

`default_nettype wire

// file: testbench/dpac_port_ctrl_props.sv
// assertion checker for the debug port access control ports
`timescale 1ns/1ps
`default_nettype none

module dpac_port_ctrl_props (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        tmsOe,
   input wire logic        tdoOe,
   input wire logic        bsDrive,
   input wire logic        lockLatch,
   input wire logic        sysResetReq,
   input wire logic [4:0]  pinRelease
);
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   logic first_r;
   logic lock_r;

   // own copy of the lockout level, taken only at the first edge after reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         first_r <= 1'b0;
         lock_r  <= 1'b0;
      end else begin
         first_r <= 1'b1;
         if (!first_r) lock_r <= lockLatch;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // a host reset request is a single clock wide
   sequence pulse_s;
      sysResetReq ##1 !sysResetReq;
   endsequence

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   reset_quiet_a: assert property (disable iff (1'b0) rst |->
      (pinRelease == 5'h00 && !sysResetReq && !tdoOe && !tmsOe && !bsDrive))
      else $error("outputs active during reset");
   default_mode_a: assert property ($past(rst) && !lockLatch |=> pinRelease == 5'h10)
      else $error("pins not in four wire tap default");
   pin_count_a: assert property (pinRelease inside {5'h10, 5'h00, 5'h1C, 5'h14, 5'h17, 5'h1F})
      else $error("claimed pin set matches no port select");
   pulse_once_a: assert property (sysResetReq |-> pulse_s)
      else $error("reset request wider than one cycle");
   off_no_reset_a: assert property (sysResetReq |-> pinRelease != 5'h1F)
      else $error("reset request with all ports off");
   tms_claimed_a: assert property (tmsOe |-> !pinRelease[1])
      else $error("mode select driven while released");
   tdo_claimed_a: assert property (tdoOe |-> !pinRelease[3])
      else $error("data out driven while released");
   scan_claimed_a: assert property (bsDrive |-> !pinRelease[0])
      else $error("boundary drive without tap clock pin");
   lock_shut_a: assert property (lock_r |=> !tdoOe && !tmsOe && !sysResetReq && !bsDrive)
      else $error("debug interface active under lockout");
endmodule : dpac_port_ctrl_props

bind dpac_port_ctrl dpac_port_ctrl_props i_dpac_port_ctrl_props (
   .clock(clock), .rst(rst), .tmsOe(tmsOe), .tdoOe(tdoOe), .bsDrive(bsDrive),
   .lockLatch(lockLatch), .sysResetReq(sysResetReq), .pinRelease(pinRelease));

`default_nettype wire

// file: testbench/dpac_probe.sv
// host probe model: drives the test clock and pins in frames
`timescale 1ns/1ps
`default_nettype none

module dpac_probe (
   output var  logic tck,
   output var  logic tms,
   output var  logic tdi,
   input  wire logic tdo,
   input  wire logic tdoOe
);
   logic lastTdo = 1'b0;
   logic line;

   // a released data out shows the inverse of its last value
   always @(tdo) if (tdoOe) lastTdo = tdo;
   assign line = tdoOe ? tdo : ~lastTdo;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one bit per 48 ns period; tck stands low between frames
   task automatic bit1(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #24 q = line;
      tck = 1'b1;
      #24 tck = 1'b0;
   endtask : bit1

   // mode select walk, first step in bit 0; no reset pin used
   task automatic walk(input logic [7:0] s, input int n);
      logic q;
      for (int i = 0; i < n; i++) bit1(s[i], 1'b0, q);
   endtask : walk

   // shift n bits lsb first, then update and back to idle
   task automatic scan(input logic [31:0] di, input int n, output logic [31:0] dq);
      logic q;
      dq = '0;
      for (int i = 0; i < n; i++) begin
         bit1(i == n - 1, di[i], q);
         dq[i] = q;
      end
      walk(8'h01, 2);
   endtask : scan

   task automatic ir(input logic [3:0] c);
      logic [31:0] q;
      walk(8'h03, 4);
      scan({28'h0, c}, 4, q);
   endtask : ir

   task automatic dr(input logic [31:0] di, input int n, output logic [31:0] dq);
      walk(8'h01, 3);
      scan(di, n, dq);
   endtask : dr
endmodule : dpac_probe

`default_nettype wire

// file: testbench/dpac_port_ctrl_bench.sv
// self-checking bench for the debug port access control
`timescale 1ns/1ps
`default_nettype none
`include "dpac_params.svh"

module dpac_port_ctrl_bench;
   logic        clock, rst, regWrStb, regRdStb, lockLatch, tck, tms, tdi;
   logic        tmsOut, tmsOe, tdoOut, tdoOe, sysResetReq, bsDrive;
   logic [3:0]  regAddr;
   logic [31:0] regWrData, regRdData, d, q;
   logic [7:0]  bsOut;
   logic [4:0]  pinRelease;
   int          bad_count = 0;
   int          tests_run = 0;
   int          pulses = 0;
   localparam logic [31:0] ID = 32'h0F0F_0A01;  // arbitrary value
   localparam logic [15:0] KEY = 16'hA55A;      // arbitrary value; each byte is its own mirror
   localparam logic [4:0]  REL [6] = '{5'h10, 5'h00, 5'h1C, 5'h14, 5'h17, 5'h1F};
   localparam logic [2:0]  USED [6] = '{3'h4, 3'h5, 3'h2, 3'h3, 3'h1, 3'h0};

   dpac_port_ctrl #(.ID_CODE(ID), .SWD_KEY(KEY), .KEY_WIN(300)) i_dpac_port_ctrl (
      .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .tckPin(tck), .tmsIn(tmsOe ? tmsOut : tms), .tmsOut(tmsOut), .tmsOe(tmsOe),
      .tdiPin(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .tapResetLowPin(1'b1),
      .bsPinsIn(8'hA5), .bsPinsOut(bsOut), .bsDrive(bsDrive), .lockLatch(lockLatch),
      .sysResetReq(sysResetReq), .pinRelease(pinRelease));
   dpac_probe i_dpac_probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoOut), .tdoOe(tdoOe));

   // ----------------------------------------------------------------
   // clock, pulse monitor and access tasks
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) if (sysResetReq === 1'b1) pulses <= pulses + 1;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clock);
      regAddr   <= a;
      regWrData <= v;
      regWrStb  <= 1'b1;
      @(posedge clock);
      regWrStb  <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clock);
      regAddr  <= a;
      regRdStb <= 1'b1;
      @(posedge clock);
      regRdStb <= 1'b0;
      #1 v = regRdData;
   endtask : rd
   task automatic rst_dut(input logic lk);
      lockLatch <= lk;
      rst       <= 1'b1;
      repeat (6) @(posedge clock);
      rst       <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : rst_dut
   task automatic rstreq(input int n);
      i_dpac_probe.walk(8'h1F, 6);
      i_dpac_probe.ir(`DPAC_IR_RSTREQ);
      i_dpac_probe.dr(32'h8000_0000, 32, q);
      repeat (4) @(posedge clock);
      chk(32'(pulses), 32'(n));
   endtask : rstreq
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   // a hang counts as a mismatch
   initial begin
      #100000;
      bad_count++;
      end_sim();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      regAddr = 4'h0;
      regWrData = 32'h0;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
      lockLatch = 1'b0;
      rst_dut(1'b0);
      chk({27'h0, pinRelease}, 32'h10);
      rd(`DPAC_OFS_STATUS, d);
      chk(d, 32'h0000_0404);
      rd(4'hF, d);
      chk(d, 32'h0);
      $display("test defaults done");
      for (int p = 0; p < 6; p++) begin
         wr(`DPAC_OFS_PORTSEL, 32'(p));
         repeat (3) @(posedge clock);
         rd(`DPAC_OFS_STATUS, d);
         chk({27'h0, pinRelease}, {27'h0, REL[p]});
         chk({29'h0, d[10:8]}, {29'h0, USED[p]});
      end
      wr(`DPAC_OFS_PORTSEL, 32'h6);
      rd(`DPAC_OFS_PORTSEL, d);
      chk(d, 32'h5);
      wr(`DPAC_OFS_PORTSEL, 32'h0);
      $display("test port select done");
      i_dpac_probe.walk(8'h1F, 5);
      rd(`DPAC_OFS_STATUS, d);
      chk({31'h0, d[2]}, 32'h1);
      i_dpac_probe.walk(8'h00, 1);
      i_dpac_probe.ir(`DPAC_IR_IDCODE);
      i_dpac_probe.dr(32'h0, 32, q);
      chk(q, ID);
      i_dpac_probe.ir(`DPAC_IR_BYPASS);
      i_dpac_probe.dr(32'h1, 2, q);
      chk(q, 32'h2);
      // boundary capture shifts out, shifted pattern lands on the drive cells
      i_dpac_probe.ir(`DPAC_IR_EXTEST);
      i_dpac_probe.dr(32'h3C, 8, q);
      chk(q, 32'hA5);
      chk({23'h0, bsDrive, bsOut}, 32'h13C);
      rstreq(1);
      wr(`DPAC_OFS_PORTSEL, 32'h5);
      rstreq(1);
      wr(`DPAC_OFS_PORTSEL, 32'h0);
      $display("test tap done");
      rd(`DPAC_OFS_STATUS, d);
      chk({31'h0, d[3]}, 32'h1);
      wr(`DPAC_OFS_CTRL, 32'h4);
      rd(`DPAC_OFS_STATUS, d);
      chk({31'h0, d[3]}, 32'h0);
      wr(`DPAC_OFS_CTRL, 32'h1);
      wr(`DPAC_OFS_CTRL, 32'h0);
      rd(`DPAC_OFS_STATUS, d);
      chk({31'h0, d[4]}, 32'h1);
      // with debug on, the host reaches both mailboxes through the tap
      wr(`DPAC_OFS_MBOX_OUT, 32'h5AC3_0F96);
      i_dpac_probe.walk(8'h00, 1);
      i_dpac_probe.ir(`DPAC_IR_DBGACC);
      i_dpac_probe.dr(32'h1234_5678, 32, q);
      rd(`DPAC_OFS_MBOX_IN, d);
      chk(q, 32'h5AC3_0F96);
      chk(d, 32'h1234_5678);
      $display("test control done");
      // key sent msb first inside the window; lsb-first walks work as the bytes mirror
      rst_dut(1'b0);
      wr(`DPAC_OFS_PORTSEL, 32'h2);
      i_dpac_probe.walk(KEY[15:8], 8);
      i_dpac_probe.walk(KEY[7:0], 8);
      #1 chk({30'h0, tmsOe, tmsOut}, 32'h3);
      i_dpac_probe.walk(8'h00, 2);
      repeat (6) @(posedge clock);
      rd(`DPAC_OFS_STATUS, d);
      chk({30'h0, d[1], tmsOe}, 32'h2);
      $display("test wire acquisition done");
      rst_dut(1'b1);
      rd(`DPAC_OFS_STATUS, d);
      chk({31'h0, d[0]}, 32'h1);
      rstreq(1);
      $display("test lockout done");
      end_sim();
   end
endmodule : dpac_port_ctrl_bench

`default_nettype wire
